/* verilog/jpd_pkg.sv */
package jpd_pkg;

    localparam int JPD_DATA_W = 8;
    localparam int JPD_FRAME_W = 9;
    localparam int JPD_IR_W = 4;
    localparam int JPD_KEY_W = 64;

    // Marker characters, always sent with the parity bit set
    localparam logic [7:0] JPD_CHR_ESC = 8'hBB;
    localparam logic [7:0] JPD_CHR_NOT_READY = 8'hDB;
    localparam logic [7:0] JPD_CHR_NO_TX = 8'hEB;
    localparam logic JPD_MARK_PAR = 1'h1;

    // Instruction codes; the communication-select code is arbitrary
    localparam logic [3:0] JPD_IR_COMM_SEL = 4'h7;
    localparam logic [3:0] JPD_IR_BYPASS = 4'hF;
    localparam logic [3:0] JPD_IR_CAPTURE = 4'h1;

    localparam logic [63:0] JPD_UNLOCK_KEY = 64'h1289AB45CDD888FF;
    localparam logic [2:0] JPD_KEY_LAST = 3'h7;

    typedef enum logic [3:0] {
        JPD_TLR = 4'b0000,
        JPD_RTI = 4'b0001,
        JPD_SEL_DR = 4'b0010,
        JPD_CAP_DR = 4'b0011,
        JPD_SH_DR = 4'b0100,
        JPD_EX1_DR = 4'b0101,
        JPD_PA_DR = 4'b0110,
        JPD_EX2_DR = 4'b0111,
        JPD_UP_DR = 4'b1000,
        JPD_SEL_IR = 4'b1001,
        JPD_CAP_IR = 4'b1010,
        JPD_SH_IR = 4'b1011,
        JPD_EX1_IR = 4'b1100,
        JPD_PA_IR = 4'b1101,
        JPD_EX2_IR = 4'b1110,
        JPD_UP_IR = 4'b1111
    } jpd_tap_t;

    typedef enum logic [1:0] {
        JPD_MODE_OFF = 2'b00,
        JPD_MODE_SCAN = 2'b01,
        JPD_MODE_TW = 2'b10
    } jpd_mode_t;

    typedef struct packed {
        logic parity;
        logic [7:0] data;
    } jpd_frame_t;

    typedef struct packed {
        logic par_err;
        logic frame_err;
        logic escape;
        logic collision;
    } jpd_exc_t;

endpackage

/* verilog/jpd_sync.sv */
module jpd_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // The first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

/* verilog/jpd_bridge.sv */
module jpd_bridge (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic two_wire_en,
    input wire logic scan_en,
    input jpd_pkg::jpd_exc_t tw_exc,
    input wire logic ctl_set_tx,
    input wire logic ctl_set_rx,
    input wire logic tx_req,
    input wire logic [7:0] tx_byte,
    output logic tx_ack,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic par_err,
    output logic esc_det,
    output logic exc_pulse,
    output logic tx_mode,
    output logic err_state,
    output logic clk_sel_tw,
    output logic scan_mode,
    output logic ctrl_init,
    input wire logic key_stb,
    input wire logic [7:0] key_byte,
    input wire logic prog_mode,
    input wire logic nvm_ctrl_en,
    input wire logic bus_req,
    output logic unlocked,
    output logic nvm_grant,
    output logic bus_req_out
);
    import jpd_pkg::*;

    logic rstn;
    logic [2:0] pin_s;
    logic tck_s, tms_s, tdi_s;
    logic tck_d_r;
    logic tck_rise, tck_fall;
    jpd_tap_t tap_r, tap_nxt;
    logic [3:0] ir_sr_r, ir_r;
    logic comm_sel;
    jpd_frame_t sr_r;
    logic byp_r;
    jpd_mode_t mode_r, mode_nxt;
    logic mode_chg;
    logic cap_fire, upd_fire;
    logic frame_perr, frame_esc;
    logic scan_act, tw_act;
    logic sc_esc, sc_exc, tw_esc, tw_exc_hit, esc_any;
    logic tx_mode_r, err_r;
    logic [63:0] key_sr_r;
    logic [63:0] key_nxt;
    logic [2:0] key_cnt_r;
    logic unlocked_r;

    jpd_sync #(.W(1)) u_rst_sync (
        .clk(ref_clk),
        .rst_n(resetn),
        .d(1'b1),
        .q(rstn)
    );

    // Scan pins are asynchronous to ref_clk; TCK is oversampled
    jpd_sync #(.W(3)) u_pin_sync (
        .clk(ref_clk),
        .rst_n(rstn),
        .d({tck, tms, tdi}),
        .q(pin_s)
    );

    assign tck_s = pin_s[2];
    assign tms_s = pin_s[1];
    assign tdi_s = pin_s[0];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tck_d_r <= 1'b0;
        end else begin
            tck_d_r <= tck_s;
        end
    end

    assign tck_rise = tck_s && !tck_d_r;
    assign tck_fall = !tck_s && tck_d_r;

    always_comb begin
        case (tap_r)
            JPD_TLR: tap_nxt = tms_s ? JPD_TLR : JPD_RTI;
            JPD_RTI: tap_nxt = tms_s ? JPD_SEL_DR : JPD_RTI;
            JPD_SEL_DR: tap_nxt = tms_s ? JPD_SEL_IR : JPD_CAP_DR;
            JPD_CAP_DR: tap_nxt = tms_s ? JPD_EX1_DR : JPD_SH_DR;
            JPD_SH_DR: tap_nxt = tms_s ? JPD_EX1_DR : JPD_SH_DR;
            JPD_EX1_DR: tap_nxt = tms_s ? JPD_UP_DR : JPD_PA_DR;
            JPD_PA_DR: tap_nxt = tms_s ? JPD_EX2_DR : JPD_PA_DR;
            JPD_EX2_DR: tap_nxt = tms_s ? JPD_UP_DR : JPD_SH_DR;
            JPD_UP_DR: tap_nxt = tms_s ? JPD_SEL_DR : JPD_RTI;
            JPD_SEL_IR: tap_nxt = tms_s ? JPD_TLR : JPD_CAP_IR;
            JPD_CAP_IR: tap_nxt = tms_s ? JPD_EX1_IR : JPD_SH_IR;
            JPD_SH_IR: tap_nxt = tms_s ? JPD_EX1_IR : JPD_SH_IR;
            JPD_EX1_IR: tap_nxt = tms_s ? JPD_UP_IR : JPD_PA_IR;
            JPD_PA_IR: tap_nxt = tms_s ? JPD_EX2_IR : JPD_PA_IR;
            JPD_EX2_IR: tap_nxt = tms_s ? JPD_UP_IR : JPD_SH_IR;
            JPD_UP_IR: tap_nxt = tms_s ? JPD_SEL_DR : JPD_RTI;
            default: tap_nxt = JPD_TLR;
        endcase
    end

    // TMS and TDI are taken on the rising edge of TCK
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tap_r <= JPD_TLR;
        end else if (tck_rise) begin
            tap_r <= tap_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ir_sr_r <= JPD_IR_CAPTURE;
            ir_r <= JPD_IR_BYPASS;
        end else if (tck_rise) begin
            case (tap_r)
                JPD_TLR: ir_r <= JPD_IR_BYPASS;
                JPD_CAP_IR: ir_sr_r <= JPD_IR_CAPTURE;
                JPD_SH_IR: ir_sr_r <= {tdi_s, ir_sr_r[3:1]};
                JPD_UP_IR: ir_r <= ir_sr_r;
                default: ir_r <= ir_r;
            endcase
        end
    end

    assign comm_sel = (ir_r == JPD_IR_COMM_SEL);
    assign cap_fire = tck_rise && (tap_r == JPD_CAP_DR) && comm_sel;
    assign upd_fire = tck_rise && (tap_r == JPD_UP_DR) && comm_sel;
    assign scan_act = (mode_r == JPD_MODE_SCAN);
    assign tw_act = (mode_r == JPD_MODE_TW);

    // Even parity: the parity bit equals the XOR of the data bits
    assign frame_perr = (^sr_r.data) ^ sr_r.parity;
    assign frame_esc = frame_perr && (sr_r.data == JPD_CHR_ESC);
    assign sc_esc = scan_act && upd_fire && frame_esc;
    assign sc_exc = scan_act && upd_fire && frame_perr;
    assign tw_esc = tw_act && tw_exc.escape;
    assign tw_exc_hit = tw_act && (tx_mode_r ? tw_exc.collision
                                   : (tw_exc.par_err || tw_exc.frame_err));
    assign esc_any = sc_esc || tw_esc;

    // Nine-bit data register, LSB of the byte first, parity last
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sr_r <= '0;
            byp_r <= 1'b0;
        end else if (tck_rise) begin
            if (cap_fire) begin
                if (!tx_mode_r) begin
                    sr_r <= {JPD_MARK_PAR, JPD_CHR_NO_TX};
                end else if (tx_req) begin
                    sr_r <= {^tx_byte, tx_byte};
                end else begin
                    sr_r <= {JPD_MARK_PAR, JPD_CHR_NOT_READY};
                end
            end else if (tap_r == JPD_SH_DR) begin
                if (comm_sel) begin
                    sr_r <= {tdi_s, sr_r[8:1]};
                end else begin
                    byp_r <= tdi_s;
                end
            end else if (tap_r == JPD_CAP_DR) begin
                byp_r <= 1'b0;
            end
        end
    end

    // Outputs move only on the falling edge of TCK
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe <= (tap_r == JPD_SH_DR) || (tap_r == JPD_SH_IR);
            if (tap_r == JPD_SH_IR) begin
                tdo <= ir_sr_r[0];
            end else if (comm_sel) begin
                tdo <= sr_r[0];
            end else begin
                tdo <= byp_r;
            end
        end
    end

    // Two-wire mode always wins over the scan port
    always_comb begin
        if (two_wire_en) begin
            mode_nxt = JPD_MODE_TW;
        end else if (scan_en && (scan_act || comm_sel)) begin
            mode_nxt = JPD_MODE_SCAN;
        end else begin
            mode_nxt = JPD_MODE_OFF;
        end
    end

    assign mode_chg = (mode_nxt != mode_r);
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= JPD_MODE_OFF;
            ctrl_init <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            ctrl_init <= mode_chg && (mode_nxt != JPD_MODE_OFF);
        end
    end

    assign clk_sel_tw = (mode_r == JPD_MODE_TW);
    assign scan_mode = scan_act;
    // Direction and error state; escape outranks every event but a mode change
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tx_mode_r <= 1'b0;
            err_r <= 1'b0;
        end else if (mode_chg) begin
            tx_mode_r <= 1'b0;
            err_r <= 1'b0;
        end else if (esc_any) begin
            tx_mode_r <= 1'b0;
            err_r <= 1'b0;
        end else if (sc_exc || tw_exc_hit) begin
            tx_mode_r <= 1'b0;
            err_r <= 1'b1;
        end else if (!err_r) begin
            if (ctl_set_tx) begin
                tx_mode_r <= 1'b1;
            end else if (ctl_set_rx) begin
                tx_mode_r <= 1'b0;
            end
        end
    end

    assign tx_mode = tx_mode_r;
    assign err_state = err_r;

    // Frames reach the controller only at Update-DR
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_valid <= 1'b0;
            rx_byte <= '0;
            par_err <= 1'b0;
            esc_det <= 1'b0;
            exc_pulse <= 1'b0;
            tx_ack <= 1'b0;
        end else begin
            rx_valid <= scan_act && upd_fire && !tx_mode_r && !err_r
                        && !frame_perr;
            if (upd_fire && scan_act) begin
                rx_byte <= sr_r.data;
            end
            par_err <= sc_exc;
            esc_det <= esc_any;
            exc_pulse <= !mode_chg && !esc_any && (sc_exc || tw_exc_hit);
            tx_ack <= cap_fire && scan_act && tx_mode_r && tx_req;
        end
    end

    // Key bytes arrive least significant byte first
    assign key_nxt = {key_byte, key_sr_r[63:8]};

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            key_sr_r <= '0;
            key_cnt_r <= '0;
            unlocked_r <= 1'b0;
        end else if (mode_chg || esc_any) begin
            key_cnt_r <= '0;
            unlocked_r <= 1'b0;
        end else if (key_stb && !err_r) begin
            key_sr_r <= key_nxt;
            key_cnt_r <= key_cnt_r + 3'h1;
            if (key_cnt_r == JPD_KEY_LAST) begin
                unlocked_r <= (key_nxt == JPD_UNLOCK_KEY);
            end
        end
    end

    assign unlocked = unlocked_r;
    assign nvm_grant = unlocked_r && prog_mode && nvm_ctrl_en
                       && !err_r;
    // A stalled controller must not touch the bus while in error
    assign bus_req_out = bus_req && !err_r
                         && (mode_r != JPD_MODE_OFF);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    a_no_tx_marker: assert property (
        cap_fire && !tx_mode_r && !mode_chg |=>
            sr_r == {JPD_MARK_PAR, JPD_CHR_NO_TX})
        else $error("wrong capture in receive mode");
    a_tx_byte_load: assert property (
        cap_fire && tx_mode_r && tx_req |=>
            sr_r == {^$past(tx_byte), $past(tx_byte)})
        else $error("valid byte not loaded with parity");
    a_not_ready_mark: assert property (
        cap_fire && tx_mode_r && !tx_req |=>
            sr_r == {JPD_MARK_PAR, JPD_CHR_NOT_READY})
        else $error("not-ready marker missing");
    a_tdo_on_fall: assert property (
        $changed(tdo) |-> $past(tck_fall))
        else $error("tdo moved away from tck fall");
    a_escape_recover: assert property (
        upd_fire && scan_act && frame_esc && !mode_chg |=>
            !err_r && !tx_mode_r && esc_det)
        else $error("escape did not restore receive state");
    a_parity_error: assert property (
        sc_exc && !frame_esc && !mode_chg |=> err_r && exc_pulse)
        else $error("parity error did not enter error state");
    a_error_quiet: assert property (
        err_r |-> !bus_req_out ##1 !rx_valid)
        else $error("activity while in error state");
    a_tw_priority: assert property (
        two_wire_en |=> clk_sel_tw && !scan_mode)
        else $error("two-wire mode did not take over");
    a_nvm_gate: assert property (
        nvm_grant |-> unlocked_r && prog_mode && nvm_ctrl_en)
        else $error("memory access granted without conditions");
    a_key_unlock: assert property (
        key_stb && !err_r && !mode_chg && !esc_any
        && key_cnt_r == JPD_KEY_LAST && key_nxt == JPD_UNLOCK_KEY
        |=> unlocked_r)
        else $error("correct key did not unlock");
    a_mode_init: assert property (
        mode_chg && mode_nxt != JPD_MODE_OFF |=>
            ctrl_init && !unlocked_r && !err_r)
        else $error("mode entry did not initialise");
    c_rx_frame: cover property (rx_valid);
    c_tx_valid: cover property (tx_ack ##[1:200] cap_fire);
    c_error_escape: cover property (err_r ##[1:1000] esc_det);
    c_unlock: cover property ($rose(unlocked_r));
endmodule

/* dv/jpd_prog_model.sv */
// Programmer on the scan port; tck stands low between frames
module jpd_prog_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    task automatic bit_io(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #80 tck = 1'b1;
        #70 q = tdo;
        #10 tck = 1'b0;
    endtask

    // Idle bits toggle tdi so a stale level is never mistaken for data
    task automatic walk(input logic m);
        logic q;
        bit_io(m, ~tdi, q);
    endtask

    task automatic tap_reset;
        #7;
        repeat (5) walk(1'b1);
        walk(1'b0);
    endtask

    task automatic ir_load(input logic [3:0] ir);
        logic q;
        #7;
        walk(1'b1);
        walk(1'b1);
        walk(1'b0);
        walk(1'b0);
        for (int i = 0; i < 4; i++) begin
            bit_io(i == 3, ir[i], q);
        end
        walk(1'b1);
        walk(1'b0);
    endtask

    // Gap in tck periods lets the far side answer slowly
    task automatic dr_xfer(input logic [8:0] f, input int gap,
                           output logic [8:0] got);
        logic q;
        #(7 + gap * 160);
        walk(1'b1);
        walk(1'b0);
        walk(1'b0);
        for (int i = 0; i < 9; i++) begin
            bit_io(i == 8, f[i], q);
            got[i] = q;
        end
        walk(1'b1);
        walk(1'b0);
    endtask
endmodule

/* dv/jpd_bridge_bench.sv */
module jpd_bridge_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import jpd_pkg::*;

    logic ref_clk, resetn, tck, tms, tdi, tdo, tdo_oe, two_wire_en, scan_en;
    logic ctl_set_tx, ctl_set_rx, tx_req, tx_ack, rx_valid, par_err, esc_det;
    logic exc_pulse, tx_mode, err_state, clk_sel_tw, scan_mode, ctrl_init;
    logic key_stb, prog_mode, nvm_ctrl_en, bus_req, unlocked, nvm_grant;
    logic bus_req_out, oe_q;
    logic [7:0] tx_byte, rx_byte, key_byte, last_rx;
    logic [8:0] got;
    jpd_exc_t tw_exc;
    int num_errors, samples_checked, cyc;
    int n_rx, n_pe, n_esc, n_exc, n_ack, n_init, n_oe;

    jpd_bridge u_dut (.ref_clk, .resetn, .tck, .tms, .tdi, .tdo, .tdo_oe,
        .two_wire_en, .scan_en, .tw_exc, .ctl_set_tx, .ctl_set_rx, .tx_req,
        .tx_byte, .tx_ack, .rx_valid, .rx_byte, .par_err, .esc_det,
        .exc_pulse, .tx_mode, .err_state, .clk_sel_tw, .scan_mode,
        .ctrl_init, .key_stb, .key_byte, .prog_mode, .nvm_ctrl_en, .bus_req,
        .unlocked, .nvm_grant, .bus_req_out);

    jpd_prog_model u_prog (.tck, .tms, .tdi, .tdo);

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Pulse counters sampled mid-cycle; the ceiling cuts a hang short
    always @(negedge ref_clk) begin
        cyc++;
        if (rx_valid === 1'b1) begin
            n_rx++;
            last_rx = rx_byte;
        end
        if (tdo_oe === 1'b1 && oe_q !== 1'b1) n_oe++;
        oe_q = tdo_oe;
        if (par_err === 1'b1) n_pe++;
        if (esc_det === 1'b1) n_esc++;
        if (exc_pulse === 1'b1) n_exc++;
        if (tx_ack === 1'b1) n_ack++;
        if (ctrl_init === 1'b1) n_init++;
        if (cyc == 30000) begin
            num_errors++;
            close_out;
        end
    end

    task automatic close_out;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [8:0] e,
                       input logic [8:0] s);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic chk_n(input string what, input int e, input int s);
        samples_checked++;
        if (s != e) begin
            num_errors++;
            $display("wrong value %s expected %0d seen %0d", what, e, s);
        end
    endtask

    function automatic logic [8:0] fr(input logic [7:0] b);
        return {^b, b};
    endfunction

    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic xfer(input logic [8:0] f, input int gap);
        u_prog.dr_xfer(f, gap, got);
        wt(6);
    endtask

    task automatic pulse_ctl(input logic to_tx);
        @(negedge ref_clk);
        ctl_set_tx = to_tx;
        ctl_set_rx = !to_tx;
        @(negedge ref_clk);
        ctl_set_tx = 1'b0;
        ctl_set_rx = 1'b0;
        wt(2);
    endtask

    task automatic tw(input logic [3:0] e);
        @(negedge ref_clk) tw_exc = e;
        @(negedge ref_clk) tw_exc = '0;
        wt(3);
    endtask

    task automatic send_key(input logic [63:0] k);
        for (int i = 0; i < 8; i++) begin
            @(negedge ref_clk);
            key_byte = k[8*i+:8];
            key_stb = 1'b1;
            @(negedge ref_clk) key_stb = 1'b0;
        end
        wt(2);
    endtask

    task automatic t_start;
        u_prog.tap_reset();
        u_prog.ir_load(4'h7);
        wt(6);
        chk("scan_mode", 1, scan_mode);
        chk_n("ctrl_init", 1, n_init);
        chk("clk_sel_tw", 0, clk_sel_tw);
        chk("unlocked", 0, unlocked);
        chk("bus_req_out", 1, bus_req_out);
    endtask

    task automatic t_rx;
        int r;
        int pe;
        int o;
        r = n_rx;
        pe = n_pe;
        o = n_oe;
        xfer(fr(8'h5A), 0);
        chk("capture rx", {1'b1, 8'hEB}, got);
        xfer(fr(8'h83), 0);
        chk_n("rx count", r + 2, n_rx);
        chk("rx_byte", 8'h83, last_rx);
        chk_n("tdo_oe", o + 2, n_oe);
        chk("tx_mode", 0, tx_mode);
        chk_n("par_err", pe, n_pe);
    endtask

    task automatic t_err;
        int pe;
        int ex;
        int r;
        pe = n_pe;
        ex = n_exc;
        xfer({1'b1, 8'h3C}, 0);
        chk_n("par_err", pe + 1, n_pe);
        chk_n("exc_pulse", ex + 1, n_exc);
        chk("err_state", 1, err_state);
        chk("bus_req_out", 0, bus_req_out);
        r = n_rx;
        xfer(fr(8'h11), 0);
        chk_n("rx in error", r, n_rx);
        pulse_ctl(1'b1);
        chk("tx in error", 0, tx_mode);
        ex = n_esc;
        xfer({1'b1, 8'hBB}, 0);
        chk_n("esc_det", ex + 1, n_esc);
        chk("err_state", 0, err_state);
        xfer({1'b1, 8'hBB}, 0);
        chk("err_state", 0, err_state);
    endtask

    task automatic t_tx;
        int a;
        pulse_ctl(1'b1);
        chk("tx_mode", 1, tx_mode);
        a = n_ack;
        xfer(fr(8'h00), 0);
        chk("not ready", {1'b1, 8'hDB}, got);
        chk_n("ack on marker", a, n_ack);
        @(negedge ref_clk);
        tx_byte = 8'hA6;
        tx_req = 1'b1;
        xfer(fr(8'h00), 3);
        chk("tx frame", {1'b0, 8'hA6}, got);
        chk_n("tx_ack", a + 1, n_ack);
        tx_req = 1'b0;
        xfer({1'b1, 8'h00}, 0);
        chk("err_state", 1, err_state);
        xfer({1'b1, 8'hBB}, 0);
        chk("err_state", 0, err_state);
        chk("tx_mode", 0, tx_mode);
    endtask

    task automatic t_key;
        send_key(64'h1289AB45CDD889FF);
        chk("bad key", 0, unlocked);
        prog_mode = 1'b1;
        nvm_ctrl_en = 1'b1;
        send_key(64'h1289AB45CDD888FF);
        chk("unlocked", 1, unlocked);
        chk("nvm_grant", 1, nvm_grant);
        @(negedge ref_clk) nvm_ctrl_en = 1'b0;
        wt(1);
        chk("grant no ctrl", 0, nvm_grant);
        nvm_ctrl_en = 1'b1;
        prog_mode = 1'b0;
        wt(1);
        chk("grant no prog", 0, nvm_grant);
        pulse_ctl(1'b1);
        pulse_ctl(1'b0);
        chk("set_rx", 0, tx_mode);
    endtask

    task automatic t_mode;
        int ni;
        ni = n_init;
        @(negedge ref_clk) two_wire_en = 1'b1;
        wt(6);
        chk("clk_sel_tw", 1, clk_sel_tw);
        chk("scan_mode", 0, scan_mode);
        chk_n("ctrl_init", ni + 1, n_init);
        chk("unlocked", 0, unlocked);
        tw(4'b1000);
        chk("tw parity", 1, err_state);
        tw(4'b0010);
        chk("tw escape", 0, err_state);
        tw(4'b0100);
        chk("tw frame", 1, err_state);
        tw(4'b0010);
        pulse_ctl(1'b1);
        tw(4'b0001);
        chk("tw collision", 1, err_state);
        tw(4'b0010);
        chk("tw escape", 0, tx_mode);
        @(negedge ref_clk) two_wire_en = 1'b0;
        wt(4);
        chk("scan again", 1, scan_mode);
        scan_en = 1'b0;
        wt(2);
        chk("scan off", 0, scan_mode);
    endtask

    initial begin
        resetn = 1'b0;
        {two_wire_en, ctl_set_tx, ctl_set_rx, tx_req, key_stb} = '0;
        {prog_mode, nvm_ctrl_en} = '0;
        scan_en = 1'b1;
        bus_req = 1'b1;
        tw_exc = '0;
        tx_byte = 8'h00;
        key_byte = 8'h00;
        repeat (12) @(negedge ref_clk);
        resetn = 1'b1;
        wt(5);
        t_start();
        t_rx();
        t_err();
        t_tx();
        t_key();
        t_mode();
        close_out();
    end
endmodule
